// ==== rtl/ptd_pkg.sv ====
/*
 * shared constants and types of the instruction timing decoder.
 * assumes: single 25 MHz system clock, byte-wide opcodes.
 */
package ptd_pkg;

   // -------------------------------------------------------------
   // widths
   // -------------------------------------------------------------
   localparam int unsigned PC_W = 16;
   localparam int unsigned CYC_W = 4;

   // -------------------------------------------------------------
   // instruction lengths in bytes
   // -------------------------------------------------------------
   localparam logic [1:0] BY1 = 2'h1;
   localparam logic [1:0] BY2 = 2'h2;
   localparam logic [1:0] BY3 = 2'h3;

   // -------------------------------------------------------------
   // execution counts in system clock cycles
   // -------------------------------------------------------------
   localparam logic [CYC_W-1:0] CY1 = 4'h1;
   localparam logic [CYC_W-1:0] CY2 = 4'h2;
   localparam logic [CYC_W-1:0] CY3 = 4'h3;
   localparam logic [CYC_W-1:0] CY4 = 4'h4;
   localparam logic [CYC_W-1:0] CY5 = 4'h5;
   localparam logic [CYC_W-1:0] CY8 = 4'h8;
   localparam logic [CYC_W-1:0] TAKEN_EXTRA = 4'h1;

   // -------------------------------------------------------------
   // opcodes and address map
   // -------------------------------------------------------------
   localparam logic [7:0] OP_NOP = 8'h00;
   localparam logic [7:0] OP_UNUSED = 8'ha5;
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [7:0] BIT_RAM_BASE = 8'h20;

   // -------------------------------------------------------------
   // instruction classes
   // -------------------------------------------------------------
   typedef enum logic [4:0] {
      K_PLAIN, K_JC, K_JNC, K_JZ, K_JNZ, K_JB, K_JNB, K_JBC,
      K_COMPARE_JUMP_UNEQUAL_AD, K_COMPARE_JUMP_UNEQUAL_AI, K_COMPARE_JUMP_UNEQUAL_RI, K_DECREMENT_JUMP_NONZERO_R, K_DECREMENT_JUMP_NONZERO_D,
      K_SHORT_RELATIVE_JUMP, K_PAGE_JUMP, K_PAGE_CALL, K_LONG_JUMP, K_LONG_CALL,
      K_JMP_IND, K_RET, K_IRET, K_CODE_DP, K_CODE_PC,
      K_XMOVE_RI, K_XMOVE_DP, K_NIBBLE_EXCHANGE
   } ptd_kind_e;

   typedef struct packed {
      logic [1:0]       len;
      logic [CYC_W-1:0] cyc;
      ptd_kind_e        kind;
   } ptd_op_s;

endpackage : ptd_pkg

// ==== rtl/ptd_dec_if.sv ====
/*
 * carrier between the timing core and its operand and condition
 * helpers. assumes: all members combinational within one cycle.
 */
`timescale 1ns/1ns
`default_nettype none
interface ptd_dec_if;
   import ptd_pkg::*;
   ptd_kind_e   kind;
   logic [7:0]  opcode;
   logic [7:0]  byte1;
   logic [7:0]  byte2;
   logic        taken;
   logic [15:0] rel_target;
   logic [15:0] page_target;
   logic [15:0] long_target;
   logic [7:0]  ram_addr;
   logic [7:0]  bit_byte;
   logic [2:0]  bit_idx;

   modport opd  (input kind, opcode, byte1, byte2,
                 output rel_target, page_target, long_target,
                 ram_addr, bit_byte, bit_idx);
   modport cnd  (input kind, opcode, byte1, byte2, output taken);
endinterface : ptd_dec_if
`default_nettype wire

// ==== rtl/ptd_operand_decode.sv ====
/*
 * operand address decode: branch targets, bank and indirect
 * register addresses, bit addresses. assumes: next_pc is the
 * address of the first byte after the current instruction.
 */
`timescale 1ns/1ns
`default_nettype none
module ptd_operand_decode (
   ptd_dec_if.opd           dec,
   input  wire logic [15:0] next_pc_i,
   input  wire logic [1:0]  bank_sel_i
);
   import ptd_pkg::*;

   logic [7:0] rel;

   always_comb begin
      // offset sits in the last byte of the instruction
      rel = (dec.kind inside {K_JB, K_JNB, K_JBC, K_COMPARE_JUMP_UNEQUAL_AD, K_COMPARE_JUMP_UNEQUAL_AI,
                              K_COMPARE_JUMP_UNEQUAL_RI, K_DECREMENT_JUMP_NONZERO_D}) ? dec.byte2
                                                    : dec.byte1;
      dec.rel_target = next_pc_i + {{8{rel[7]}}, rel};
      dec.page_target = {next_pc_i[15:11], dec.opcode[7:5],
                         dec.byte1};
      dec.long_target = {dec.byte1, dec.byte2};
      // only r0/r1 serve as pointers, bank picks the group
      if (dec.opcode[3])
         dec.ram_addr = {3'h0, bank_sel_i, dec.opcode[2:0]};
      else
         dec.ram_addr = {3'h0, bank_sel_i, 2'h0, dec.opcode[0]};
      if (dec.byte1[7])
         dec.bit_byte = {dec.byte1[7:3], 3'h0};
      else
         dec.bit_byte = BIT_RAM_BASE + {4'h0, dec.byte1[6:3]};
      dec.bit_idx = dec.byte1[2:0];
   end

endmodule : ptd_operand_decode
`default_nettype wire

// ==== rtl/ptd_branch_cond.sv ====
/*
 * branch condition evaluation for all conditional jumps.
 * assumes: operand_value is the direct, indirect or bank register
 * byte that the instruction names, read in the issue cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module ptd_branch_cond (
   ptd_dec_if.cnd          dec,
   input  wire logic [7:0] acc_i,
   input  wire logic       carry_i,
   input  wire logic       bit_value_i,
   input  wire logic [7:0] operand_value_i
);
   import ptd_pkg::*;

   logic [7:0] dec_val;

   always_comb begin
      dec_val = operand_value_i - 8'h01;
      unique case (dec.kind)
         K_JC:      dec.taken = carry_i;
         K_JNC:     dec.taken = !carry_i;
         K_JZ:      dec.taken = (acc_i == 8'h00);
         K_JNZ:     dec.taken = (acc_i != 8'h00);
         K_JB,
         K_JBC:     dec.taken = bit_value_i;
         K_JNB:     dec.taken = !bit_value_i;
         K_COMPARE_JUMP_UNEQUAL_AD: dec.taken = (acc_i != operand_value_i);
         K_COMPARE_JUMP_UNEQUAL_AI: dec.taken = (acc_i != dec.byte1);
         K_COMPARE_JUMP_UNEQUAL_RI: dec.taken = (operand_value_i != dec.byte1);
         K_DECREMENT_JUMP_NONZERO_R,
         K_DECREMENT_JUMP_NONZERO_D:  dec.taken = (dec_val != 8'h00);
         default:   dec.taken = 1'b0;
      endcase
   end

endmodule : ptd_branch_cond
`default_nettype wire

// ==== rtl/ptd_timing_core.sv ====
/*
 * instruction decode and cycle timing for a pipelined byte-wide
 * core: length and cycle table, operand addresses, completion timer.
 * assumes: a whole instruction is offered with instr_valid;
 * condition inputs are valid with it.
 */
// Overview of operation
// - code byte reads: one byte, 3 cycles
// - external data moves: one byte, 3 cycles
// - data pointer load: three bytes, 3 cycles
// - direct move 3 bytes 3 cycles; direct/indirect 2 cycles
// - push and pop: two bytes, 2 cycles
// - nibble exchange: one byte, 2 cycles
// - accumulator ops: one byte, 1 cycle
// - carry ops 1 byte 1 cycle; bit ops 2 bytes 2 cycles
// - jump on carry: two bytes, 2/3 cycles
// - jump on bit: 3 bytes 3/4 cycles; clear variant clears bit
// - page call 2 bytes 3 cycles; long call 3 bytes 4
// - returns: one byte, 5 cycles
// - page jump 3, long 4, short 3, indirect 3 cycles
// - jump on accumulator: two bytes, 2/3 cycles
// - compare-jump: 3 bytes; 4/5 or 3/4 cycles by form
// - decrement-jump: register 2 bytes 2/3; direct 3 bytes 3/4
// - signed offset added to following byte address
// - direct below 0x80 is ram, above is sfr
// - page target replaces low 11 bits, same 2 kB page
// - long target reaches any program location
// - unused opcode 0xa5 acts as no-operation
// - indirect uses r0/r1 of bank; bank register one of 8
// - not-taken branches end one cycle sooner
// - timing in plain system clocks
`timescale 1ns/1ns
`default_nettype none
module ptd_timing_core (
   input  wire logic                  clock_i,
   input  wire logic                  sys_rst_i,
   input  wire logic                  instr_valid_i,
   input  wire logic [7:0]            opcode_i,
   input  wire logic [7:0]            operand1_i,
   input  wire logic [7:0]            operand2_i,
   input  wire logic [15:0]           next_pc_i,
   input  wire logic [7:0]            acc_i,
   input  wire logic                  carry_i,
   input  wire logic                  bit_value_i,
   input  wire logic [7:0]            operand_value_i,
   input  wire logic [15:0]           data_pointer_i,
   input  wire logic [1:0]            bank_sel_i,
   output logic                       instr_ready_o,
   output logic                       instr_done_o,
   output logic [1:0]                 instr_length_o,
   output logic [ptd_pkg::CYC_W-1:0]  instr_cycles_o,
   output ptd_pkg::ptd_kind_e         instr_kind_o,
   output logic                       branch_taken_o,
   output logic                       pc_load_o,
   output logic [15:0]                pc_target_o,
   output logic [7:0]                 direct_addr_o,
   output logic                       direct_is_sfr_o,
   output logic [7:0]                 ram_addr_o,
   output logic [7:0]                 bit_byte_addr_o,
   output logic [2:0]                 bit_index_o,
   output logic                       clear_bit_o,
   output logic [15:0]                xfer_addr_o
);
   import ptd_pkg::*;

   // ----------------------------------------------------------------
   // length and cycle table
   // ----------------------------------------------------------------
   function automatic ptd_op_s op_info(input logic [7:0] op);
      ptd_op_s r;
      r = '{len: BY1, cyc: CY1, kind: K_PLAIN};
      if (op[3:0] == 4'h1) begin
         if (op[4])
            r = '{len: BY2, cyc: CY3, kind: K_PAGE_CALL};
         else
            r = '{len: BY2, cyc: CY3, kind: K_PAGE_JUMP};
      end else begin
         case (op)
            OP_NOP, OP_UNUSED:
               r = '{len: BY1, cyc: CY1, kind: K_PLAIN};
            8'h02: r = '{len: BY3, cyc: CY4, kind: K_LONG_JUMP};
            8'h12: r = '{len: BY3, cyc: CY4, kind: K_LONG_CALL};
            8'h22: r = '{len: BY1, cyc: CY5, kind: K_RET};
            8'h32: r = '{len: BY1, cyc: CY5, kind: K_IRET};
            8'h10: r = '{len: BY3, cyc: CY3, kind: K_JBC};
            8'h20: r = '{len: BY3, cyc: CY3, kind: K_JB};
            8'h30: r = '{len: BY3, cyc: CY3, kind: K_JNB};
            8'h40: r = '{len: BY2, cyc: CY2, kind: K_JC};
            8'h50: r = '{len: BY2, cyc: CY2, kind: K_JNC};
            8'h60: r = '{len: BY2, cyc: CY2, kind: K_JZ};
            8'h70: r = '{len: BY2, cyc: CY2, kind: K_JNZ};
            8'h80: r = '{len: BY2, cyc: CY3, kind: K_SHORT_RELATIVE_JUMP};
            8'h73: r = '{len: BY1, cyc: CY3, kind: K_JMP_IND};
            8'h83: r = '{len: BY1, cyc: CY3, kind: K_CODE_PC};
            8'h93: r = '{len: BY1, cyc: CY3, kind: K_CODE_DP};
            8'h90: r = '{len: BY3, cyc: CY3, kind: K_PLAIN};
            8'h85, 8'h75: r = '{len: BY3, cyc: CY3, kind: K_PLAIN};
            8'h86, 8'h87, 8'ha6, 8'ha7,
            8'h76, 8'h77: r = '{len: BY2, cyc: CY2, kind: K_PLAIN};
            8'hc0, 8'hd0: r = '{len: BY2, cyc: CY2, kind: K_PLAIN};
            8'hd6, 8'hd7:
               r = '{len: BY1, cyc: CY2, kind: K_NIBBLE_EXCHANGE};
            8'he0, 8'hf0:
               r = '{len: BY1, cyc: CY3, kind: K_XMOVE_DP};
            8'he2, 8'he3, 8'hf2, 8'hf3:
               r = '{len: BY1, cyc: CY3, kind: K_XMOVE_RI};
            8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4,
            8'h04, 8'h14, 8'hd4, 8'ha3:
               r = '{len: BY1, cyc: CY1, kind: K_PLAIN};
            8'hc3, 8'hd3, 8'hb3:
               r = '{len: BY1, cyc: CY1, kind: K_PLAIN};
            8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0,
            8'ha2, 8'h92:
               r = '{len: BY2, cyc: CY2, kind: K_PLAIN};
            8'hb4: r = '{len: BY3, cyc: CY3, kind: K_COMPARE_JUMP_UNEQUAL_AI};
            8'hb5: r = '{len: BY3, cyc: CY4, kind: K_COMPARE_JUMP_UNEQUAL_AD};
            8'hb6, 8'hb7:
               r = '{len: BY3, cyc: CY4, kind: K_COMPARE_JUMP_UNEQUAL_RI};
            8'hd5: r = '{len: BY3, cyc: CY3, kind: K_DECREMENT_JUMP_NONZERO_D};
            8'ha4: r = '{len: BY1, cyc: CY4, kind: K_PLAIN};
            8'h84: r = '{len: BY1, cyc: CY8, kind: K_PLAIN};
            8'h42, 8'h52, 8'h62:
               r = '{len: BY2, cyc: CY2, kind: K_PLAIN};
            8'h43, 8'h53, 8'h63:
               r = '{len: BY3, cyc: CY3, kind: K_PLAIN};
            default: begin
               // column decode of the regular operand forms
               if (op[3]) begin
                  unique case (op[7:4])
                     4'h7, 4'h8, 4'ha:
                        r = '{len: BY2, cyc: CY2, kind: K_PLAIN};
                     4'hb:
                        r = '{len: BY3, cyc: CY3,
                              kind: K_COMPARE_JUMP_UNEQUAL_RI};
                     4'hd:
                        r = '{len: BY2, cyc: CY2,
                              kind: K_DECREMENT_JUMP_NONZERO_R};
                     default:
                        r = '{len: BY1, cyc: CY1, kind: K_PLAIN};
                  endcase
               end else if (op[3:1] == 3'h3)
                  r = '{len: BY1, cyc: CY2, kind: K_PLAIN};
               else if (op[3:0] == 4'h4 || op[3:0] == 4'h5)
                  r = '{len: BY2, cyc: CY2, kind: K_PLAIN};
               else
                  r = '{len: BY1, cyc: CY1, kind: K_PLAIN};
            end
         endcase
      end
      return r;
   endfunction : op_info

   function automatic logic is_cond(input ptd_kind_e k);
      return k inside {K_JC, K_JNC, K_JZ, K_JNZ, K_JB, K_JNB, K_JBC,
                       K_COMPARE_JUMP_UNEQUAL_AD, K_COMPARE_JUMP_UNEQUAL_AI, K_COMPARE_JUMP_UNEQUAL_RI, K_DECREMENT_JUMP_NONZERO_R,
                       K_DECREMENT_JUMP_NONZERO_D};
   endfunction : is_cond

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   ptd_dec_if dec ();
   ptd_op_s   info;

   assign info = op_info(opcode_i);
   assign dec.kind = info.kind;
   assign dec.opcode = opcode_i;
   assign dec.byte1 = operand1_i;
   assign dec.byte2 = operand2_i;

   ptd_operand_decode u_opd (
      .dec        (dec),
      .next_pc_i  (next_pc_i),
      .bank_sel_i (bank_sel_i)
   );

   ptd_branch_cond u_cnd (
      .dec             (dec),
      .acc_i           (acc_i),
      .carry_i         (carry_i),
      .bit_value_i     (bit_value_i),
      .operand_value_i (operand_value_i)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic {ST_IDLE, ST_EXEC} ptd_state_e;

   typedef struct packed {
      ptd_state_e       st;
      logic [CYC_W-1:0] count;
      logic             ready;
      logic             done;
      logic [1:0]       len;
      logic [CYC_W-1:0] cyc;
      ptd_kind_e        kind;
      logic             taken;
      logic             pc_load;
      logic [15:0]      target;
      logic [7:0]       direct;
      logic             is_sfr;
      logic [7:0]       ram_addr;
      logic [7:0]       bit_byte;
      logic [2:0]       bit_idx;
      logic             clr_bit;
      logic [15:0]      xfer;
   } ptd_core_s;

   ptd_core_s        s_r;
   ptd_core_s        s_nxt;
   logic             accept;
   logic             cond_taken;
   logic [CYC_W-1:0] run_cyc;

   assign accept = instr_valid_i && s_r.ready;
   assign cond_taken = is_cond(info.kind) && dec.taken;
   // not-taken is the base count, taken adds one
   assign run_cyc = cond_taken ? info.cyc + TAKEN_EXTRA
                               : info.cyc;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      unique case (s_r.st)
         ST_IDLE: ;
         ST_EXEC: begin
            // plain clock count, one step per edge
            s_nxt.count = s_r.count - CY1;
            if (s_r.count == CY1) begin
               s_nxt.done = 1'b1;
               s_nxt.st = ST_IDLE;
            end
         end
      endcase
      if (accept) begin
         s_nxt.len = info.len;
         s_nxt.cyc = run_cyc;
         s_nxt.kind = info.kind;
         s_nxt.taken = cond_taken;
         s_nxt.count = run_cyc - CY1;
         s_nxt.done = (run_cyc == CY1);
         s_nxt.st = (run_cyc == CY1) ? ST_IDLE : ST_EXEC;
         s_nxt.direct = operand1_i;
         s_nxt.is_sfr = (operand1_i >= SFR_BASE);
         s_nxt.ram_addr = dec.ram_addr;
         s_nxt.bit_byte = dec.bit_byte;
         s_nxt.bit_idx = dec.bit_idx;
         s_nxt.clr_bit = (info.kind == K_JBC) && dec.taken;
         s_nxt.xfer = 16'h0000;
         unique case (info.kind)
            K_CODE_DP: s_nxt.xfer = data_pointer_i + {8'h00, acc_i};
            K_CODE_PC: s_nxt.xfer = next_pc_i + {8'h00, acc_i};
            K_XMOVE_DP: s_nxt.xfer = data_pointer_i;
            K_XMOVE_RI: s_nxt.xfer = {8'h00, operand_value_i};
            default: ;
         endcase
         s_nxt.pc_load = 1'b1;
         s_nxt.target = 16'h0000;
         unique case (info.kind)
            K_PAGE_JUMP, K_PAGE_CALL:
               s_nxt.target = dec.page_target;
            K_LONG_JUMP, K_LONG_CALL:
               s_nxt.target = dec.long_target;
            K_SHORT_RELATIVE_JUMP: s_nxt.target = dec.rel_target;
            K_JMP_IND:
               s_nxt.target = data_pointer_i + {8'h00, acc_i};
            default: begin
               s_nxt.pc_load = cond_taken;
               if (cond_taken)
                  s_nxt.target = dec.rel_target;
            end
         endcase
      end
      s_nxt.ready = (s_nxt.st == ST_IDLE);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         s_r <= '{st: ST_IDLE, ready: 1'b1, len: BY1, cyc: CY1,
                  kind: K_PLAIN, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign instr_ready_o = s_r.ready;
   assign instr_done_o = s_r.done;
   assign instr_length_o = s_r.len;
   assign instr_cycles_o = s_r.cyc;
   assign instr_kind_o = s_r.kind;
   assign branch_taken_o = s_r.taken;
   assign pc_load_o = s_r.pc_load;
   assign pc_target_o = s_r.target;
   assign direct_addr_o = s_r.direct;
   assign direct_is_sfr_o = s_r.is_sfr;
   assign ram_addr_o = s_r.ram_addr;
   assign bit_byte_addr_o = s_r.bit_byte;
   assign bit_index_o = s_r.bit_idx;
   assign clear_bit_o = s_r.clr_bit;
   assign xfer_addr_o = s_r.xfer;

endmodule : ptd_timing_core
`default_nettype wire

// ==== sim/ptd_data_mem.sv ====
/* far-side model: internal data ram and sfr space.
   assumes: written on clock_i, read combinationally. */
`timescale 1ns/1ns
`default_nettype none
module ptd_data_mem (
   input  wire logic       clock_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   output logic      [7:0] rdata_o
);
   logic [7:0] ram_r [128];
   logic [7:0] sfr_r [128];
   // -----------------------------------
   // low half ram, high half sfr
   // -----------------------------------
   always_ff @(posedge clock_i) begin
      if (wr_i && !addr_i[7]) ram_r[addr_i[6:0]] <= wdata_i;
      if (wr_i && addr_i[7]) sfr_r[addr_i[6:0]] <= wdata_i;
   end
   assign rdata_o = addr_i[7] ? sfr_r[addr_i[6:0]] : ram_r[addr_i[6:0]];
endmodule : ptd_data_mem
`default_nettype wire

// ==== sim/ptd_timing_core_props.sv ====
/* timing and operand checks on the decoder top ports.
   assumes: bound to ptd_timing_core, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module ptd_timing_core_props (
   input wire logic               clock_i,
   input wire logic               sys_rst_i,
   input wire logic               instr_valid_i,
   input wire logic [7:0]         opcode_i,
   input wire logic [7:0]         operand1_i,
   input wire logic [7:0]         operand2_i,
   input wire logic [15:0]        next_pc_i,
   input wire logic               carry_i,
   input wire logic [1:0]         bank_sel_i,
   input wire logic               instr_ready_o,
   input wire logic               instr_done_o,
   input wire logic [1:0]         instr_length_o,
   input wire logic [3:0]         instr_cycles_o,
   input wire ptd_pkg::ptd_kind_e instr_kind_o,
   input wire logic               branch_taken_o,
   input wire logic               pc_load_o,
   input wire logic [15:0]        pc_target_o,
   input wire logic               direct_is_sfr_o,
   input wire logic [7:0]         ram_addr_o
);
   import ptd_pkg::*;
   wire logic tk = instr_valid_i && instr_ready_o;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   // -----------------------------------
   // assertions
   // -----------------------------------
   a_unused_nop: assert property (tk && opcode_i == 8'ha5 |=>
      instr_length_o == 2'h1 && instr_cycles_o == 4'h1 && instr_done_o)
      else $error("unused opcode timing wrong");
   a_return_five: assert property (tk && opcode_i[7:5] == 3'h1 &&
      opcode_i[3:0] == 4'h2 |=> !instr_done_o [*4] ##1 instr_done_o)
      else $error("return not five cycles");
   a_carry_jump: assert property (tk && opcode_i == 8'h40 |=>
      branch_taken_o == $past(carry_i) && pc_load_o == $past(carry_i)
      ##1 instr_done_o == !$past(carry_i, 2))
      else $error("carry jump timing wrong");
   a_sfr_split: assert property (tk && opcode_i == 8'he5 |=>
      direct_is_sfr_o == $past(operand1_i[7]))
      else $error("direct space select wrong");
   a_long_target: assert property (tk && opcode_i == 8'h02 |=>
      pc_load_o && pc_target_o == {$past(operand1_i), $past(operand2_i)})
      else $error("long target wrong");
   a_page_target: assert property (tk && opcode_i[4:0] == 5'h01 |=>
      pc_target_o == {$past(next_pc_i[15:11]), $past(opcode_i[7:5]),
      $past(operand1_i)})
      else $error("page target wrong");
   a_rel_target: assert property (tk && opcode_i == 8'h80 |=>
      pc_target_o == $past(next_pc_i) + {{8{$past(operand1_i[7])}},
      $past(operand1_i)})
      else $error("relative target wrong");
   a_bank_reg: assert property (tk && opcode_i[7:3] == 5'h1d |=>
      ram_addr_o == {3'h0, $past(bank_sel_i), $past(opcode_i[2:0])})
      else $error("bank register address wrong");
   a_refused_hold: assert property (instr_valid_i && !instr_ready_o
      |=> $stable(instr_kind_o) && $stable(pc_target_o))
      else $error("refused request changed outputs");
endmodule : ptd_timing_core_props
bind ptd_timing_core ptd_timing_core_props u_props (.*);
`default_nettype wire

// ==== sim/pipelined_instr_timing_decoder_tb.sv ====
/* self-checking bench for the timing decoder.
   assumes: package, design and ram model compiled first. */
`timescale 1ns/1ns
`default_nettype none
module pipelined_instr_timing_decoder_tb;
   import ptd_pkg::*;
   logic        clock_i = 1'b0, sys_rst_i = 1'b1, instr_valid_i = 1'b0;
   logic        carry_i = 1'b0, bit_value_i = 1'b0, mem_wr = 1'b1;
   logic [1:0]  bank_sel_i = 2'h0;
   logic [7:0]  opcode_i = 8'h00, operand1_i = 8'h00, operand2_i = 8'h00;
   logic [7:0]  acc_i = 8'h00, mem_wdata = 8'h00, operand_value_i;
   logic [15:0] next_pc_i = 16'h1234, data_pointer_i = 16'h0000;
   logic        instr_ready_o, instr_done_o, branch_taken_o, pc_load_o;
   logic        direct_is_sfr_o, clear_bit_o;
   logic [1:0]  instr_length_o;
   logic [3:0]  instr_cycles_o;
   ptd_kind_e   instr_kind_o;
   logic [15:0] pc_target_o, xfer_addr_o;
   logic [7:0]  direct_addr_o, ram_addr_o, bit_byte_addr_o;
   logic [2:0]  bit_index_o;
   int          n_mismatch = 0, checks_done = 0, cyc_cnt = 0, n;
   localparam logic [15:0] PL[35] = '{
      16'he411, 16'hf411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
      16'hc411, 16'hc311, 16'hd311, 16'hb222, 16'h8222, 16'ha022,
      16'h9313, 16'h8313, 16'he013, 16'he213, 16'hf013, 16'hf213,
      16'h9033, 16'h8533, 16'h8622, 16'ha622, 16'hc022, 16'hd022,
      16'hd612, 16'h2215, 16'h3215, 16'h1123, 16'h1234, 16'h0123,
      16'h0234, 16'h8023, 16'h7313, 16'ha511, 16'h0011};
   localparam logic [23:0] CT[13] = '{
      24'h402202, 24'h502201, 24'h602202, 24'h702201, 24'h203302,
      24'h303301, 24'h103302, 24'hb53403, 24'hb43302, 24'hb63401,
      24'hb83301, 24'hd82201, 24'hd53301};
   localparam logic [39:0] TT[6] = '{
      40'h80fe001232, 40'h807f0012b3, 40'h40fe001232,
      40'he155001755, 40'hf155001755, 40'h02abcdabcd};
   ptd_timing_core dut (.*);
   ptd_data_mem u_mem (.clock_i, .wr_i(mem_wr), .addr_i(8'h00),
      .wdata_i(mem_wdata), .rdata_o(operand_value_i));
   always #20 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         n_mismatch++;
         end_sim();
      end
   end
   // -----------------------------------
   // shared tasks
   // -----------------------------------
   task automatic check(input string nm, input logic [15:0] exp, seen);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic issue(input logic [7:0] op, b1, b2);
      opcode_i <= op;
      operand1_i <= b1;
      operand2_i <= b2;
      instr_valid_i <= 1'b1;
      do @(posedge clock_i); while (instr_ready_o !== 1'b1);
      instr_valid_i <= 1'b0;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (instr_done_o !== 1'b1 && n < 12);
   endtask : issue
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim
   // -----------------------------------
   // scenarios
   // -----------------------------------
   task automatic t_plain();
      for (int i = 0; i < 35; i++) begin
         issue(PL[i][15:8], 8'h01, 8'h02);
         check("cycles", {12'h0, PL[i][3:0]}, n[15:0]);
         check("length", {14'h0, PL[i][5:4]}, {14'h0, instr_length_o});
      end
      $display("t_plain finished");
   endtask : t_plain
   task automatic t_cond();
      logic tk;
      logic cb;
      for (int s = 0; s < 2; s++) begin
         carry_i <= (s == 0);
         bit_value_i <= (s == 0);
         acc_i <= s[7:0];
         mem_wdata <= 8'(s + 1);
         mem_wr <= 1'b1;
         @(posedge clock_i);
         mem_wr <= 1'b0;
         for (int i = 0; i < 13; i++) begin
            tk = CT[i][1-s];
            cb = tk && CT[i][23:16] == 8'h10;
            issue(CT[i][23:16], 8'h01, 8'h01);
            check("cond cycles", {12'h0, CT[i][11:8] + 4'(tk)}, n[15:0]);
            check("taken", {15'h0, tk}, {15'h0, branch_taken_o});
            check("clear bit", {15'h0, cb}, {15'h0, clear_bit_o});
         end
      end
      $display("t_cond finished");
   endtask : t_cond
   task automatic t_targets();
      carry_i <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         issue(TT[i][39:32], TT[i][31:24], TT[i][23:16]);
         check("target", TT[i][15:0], pc_target_o);
         check("pc load", 16'h1, {15'h0, pc_load_o});
      end
      carry_i <= 1'b0;
      issue(8'h40, 8'hfe, 8'h00);
      check("pc load", 16'h0, {15'h0, pc_load_o});
      $display("t_targets finished");
   endtask : t_targets
   task automatic t_addr();
      issue(8'he5, 8'h7f, 8'h00);
      check("sfr", 16'h0, {15'h0, direct_is_sfr_o});
      issue(8'he5, 8'h80, 8'h00);
      check("sfr", 16'h1, {15'h0, direct_is_sfr_o});
      issue(8'hc2, 8'h9b, 8'h00);
      check("bit byte", 16'h98, {8'h0, bit_byte_addr_o});
      check("bit index", 16'h3, {13'h0, bit_index_o});
      check("direct", 16'h9b, {8'h0, direct_addr_o});
      bank_sel_i <= 2'h2;
      issue(8'he7, 8'h00, 8'h00);
      check("ram addr", 16'h11, {8'h0, ram_addr_o});
      bank_sel_i <= 2'h3;
      issue(8'hed, 8'h00, 8'h00);
      check("ram addr", 16'h1d, {8'h0, ram_addr_o});
      data_pointer_i <= 16'h1000;
      acc_i <= 8'h05;
      issue(8'h93, 8'h00, 8'h00);
      check("xfer", 16'h1005, xfer_addr_o);
      data_pointer_i <= 16'hbeef;
      issue(8'he0, 8'h00, 8'h00);
      check("xfer", 16'hbeef, xfer_addr_o);
      $display("t_addr finished");
   endtask : t_addr
   task automatic t_b2b();
      int d;
      d = 0;
      opcode_i <= 8'ha5;
      instr_valid_i <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge clock_i);
         if (instr_done_o === 1'b1) d++;
         if (i == 5) instr_valid_i <= 1'b0;
      end
      check("b2b dones", 16'h6, d[15:0]);
      $display("t_b2b finished");
   endtask : t_b2b
   initial begin
      repeat (8) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      mem_wr <= 1'b0;
      check("ready", 16'h1, {15'h0, instr_ready_o});
      check("cycles", 16'h1, {12'h0, instr_cycles_o});
      t_cond();
      t_plain();
      t_targets();
      t_addr();
      t_b2b();
      end_sim();
   end
endmodule : pipelined_instr_timing_decoder_tb
`default_nettype wire
